// *** hw/isss_pkg.sv ***
// constants, types and reset values of the two-wire slave status sequencer
package isss_pkg;

  // ****************************************************************
  // register map (word index on the plain register port)
  // ****************************************************************
  localparam logic [1:0] ISSS_ADDR_CTRL = 2'h0;
  localparam logic [1:0] ISSS_ADDR_STATUS = 2'h1;
  localparam logic [1:0] ISSS_ADDR_DATA = 2'h2;
  localparam logic [1:0] ISSS_ADDR_OWN = 2'h3;

  // control register bit positions
  localparam int ISSS_CTRL_EN_BIT = 0;
  localparam int ISSS_CTRL_ACK_BIT = 2;
  localparam int ISSS_CTRL_SI_BIT = 3;
  localparam int ISSS_CTRL_STOP_BIT = 4;
  localparam int ISSS_CTRL_START_BIT = 5;
  localparam int ISSS_CTRL_IE_BIT = 6;
  // own address register: bit 0 accepts the general call
  localparam int ISSS_OWN_GC_BIT = 0;

  // ****************************************************************
  // status codes
  // ****************************************************************
  localparam logic [7:0] ISSS_CODE_BUS_ERR = 8'h00;
  localparam logic [7:0] ISSS_CODE_SLA_W = 8'h60;
  localparam logic [7:0] ISSS_CODE_ARB_SLA_W = 8'h68;
  localparam logic [7:0] ISSS_CODE_GC = 8'h70;
  localparam logic [7:0] ISSS_CODE_ARB_GC = 8'h78;
  localparam logic [7:0] ISSS_CODE_RX_ACK = 8'h80;
  localparam logic [7:0] ISSS_CODE_RX_NACK = 8'h88;
  localparam logic [7:0] ISSS_CODE_GC_ACK = 8'h90;
  localparam logic [7:0] ISSS_CODE_GC_NACK = 8'h98;
  localparam logic [7:0] ISSS_CODE_STOP = 8'ha0;
  localparam logic [7:0] ISSS_CODE_SLA_R = 8'ha8;
  localparam logic [7:0] ISSS_CODE_ARB_SLA_R = 8'hb0;
  localparam logic [7:0] ISSS_CODE_TX_ACK = 8'hb8;
  localparam logic [7:0] ISSS_CODE_TX_NACK = 8'hc0;
  localparam logic [7:0] ISSS_CODE_TX_LAST = 8'hc8;
  localparam logic [7:0] ISSS_CODE_IDLE = 8'hf8;

  // bits per byte on the wire and the count after the ninth clock
  localparam logic [3:0] ISSS_BYTE_BITS = 4'h8;
  localparam logic [3:0] ISSS_ACK_BITS = 4'h9;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_HOLD} isss_fsm_t;
  typedef enum logic [2:0] {ROLE_NONE, ROLE_MT, ROLE_MR, ROLE_ST, ROLE_SR, ROLE_GC} isss_role_t;

  typedef struct packed {
    logic en;
    logic ie;
    logic start_request_bit;
    logic stop_request_bit;
    logic ack_enable_bit;
    logic si;
  } isss_ctrl_t;

  typedef struct packed {
    logic scl_meta;
    logic scl_sync;
    logic scl_prev;
    logic sda_meta;
    logic sda_sync;
    logic sda_prev;
  } isss_sync_t;

  typedef struct packed {
    isss_fsm_t fsm;
    isss_fsm_t resume;
    isss_role_t role;
    isss_ctrl_t ctrl;
    isss_sync_t pins;
    logic [7:0] own_slave_addr_reg;
    logic [7:0] serial_data_reg;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic [4:0] pcode;
    logic [4:0] code;
    logic si_dly;
    logic last;
    logic mack;
    logic sda_low;
    logic [7:0] rdata;
  } isss_state_t;

  // value after reset: lines idle high, status idle
  localparam isss_state_t ISSS_RESET = '{
    fsm: ST_IDLE, resume: ST_IDLE, role: ROLE_NONE, ctrl: '0, pins: 6'h3f,
    own_slave_addr_reg: 8'h00, serial_data_reg: 8'h00, shift: 8'h00, cnt: 4'h0,
    pcode: ISSS_CODE_IDLE[7:3], code: ISSS_CODE_IDLE[7:3], si_dly: 1'b0, last: 1'b0,
    mack: 1'b0, sda_low: 1'b0, rdata: 8'h00};

endpackage : isss_pkg

// *** hw/isss_top.sv ***
// two-wire slave engine with status codes and software step control
`timescale 1ns/1ns
// How it works
// - own address write acked: 60, after arbitration 68
// - general call acked: 70, after arbitration 78
// - own-addressed data: 80 acked, 88 not acked
// - general call data: 90 acked, 98 other
// - stop or restart while addressed gives A0
// - own address read acked: A8, after arbitration B0
// - transmitted byte acked by master gives B8
// - transmitted byte not acked gives C0
// - final byte still acked gives C8
// - status reads F8 while the flag is clear and was clear the cycle before
// - track slave transmit, slave receive and general call roles
// - control bits choose action after flag clear
// - new code and flag set together
// - interrupt request when flag and enable set
// - status read-only, low three bits zero
// - code valid while the flag is set and one cycle past its clear
// - upper seven address bits are own address
// - misplaced start or stop gives code 00
module isss_top
  import isss_pkg::*;
(
  input wire logic clk_in,              // system clock, 20 MHz
  input wire logic reset_in,            // synchronous reset, active high
  input wire logic [1:0] reg_addr_in,   // register index
  input wire logic [7:0] reg_wdata_in,  // register write data
  input wire logic reg_wr_in,           // write strobe
  input wire logic reg_rd_in,           // read strobe
  output logic [7:0] reg_rdata_out,     // read data, cycle after strobe
  input wire logic arb_lost_in,         // master section lost arbitration
  input wire logic scl_in,              // clock line level
  output logic scl_out,                 // clock line drive value
  output logic scl_oe_out,              // clock line pulled low
  input wire logic sda_in,              // data line level
  output logic sda_out,                 // data line drive value
  output logic sda_oe_out,              // data line pulled low
  output logic irq_out,                 // interrupt request
  output isss_role_t role_out           // present operating role
);

  // ****************************************************************
  // state
  // ****************************************************************
  isss_state_t q;
  isss_state_t d;

  // status byte as software sees it
  function automatic logic [7:0] status_view(input isss_state_t s);
    // keeps the code one cycle past the clear so a late read still sees it
    status_view = (s.ctrl.si || s.si_dly) ? {s.code, 3'h0} : ISSS_CODE_IDLE;
  endfunction : status_view

  // own address match on the seven upper bits
  function automatic logic own_match(input logic [7:0] rx, input logic [7:0] own);
    own_match = (rx[7:1] == own[7:1]);
  endfunction : own_match

  // ****************************************************************
  // pin events
  // ****************************************************************
  logic scl_rise, scl_fall, start_det, stop_det, addressed, mid_frame;

  // edges seen on the second and third sampling stages only
  assign scl_rise = q.pins.scl_sync & ~q.pins.scl_prev;
  assign scl_fall = ~q.pins.scl_sync & q.pins.scl_prev;
  assign start_det = q.pins.scl_sync & q.pins.scl_prev & q.pins.sda_prev & ~q.pins.sda_sync;
  assign stop_det = q.pins.scl_sync & q.pins.scl_prev & ~q.pins.sda_prev & q.pins.sda_sync;
  assign addressed = (q.role == ROLE_ST) || (q.role == ROLE_SR) || (q.role == ROLE_GC);
  // misplaced inside a byte or its acknowledge; the first clock of a byte carries legal stops
  assign mid_frame = (q.fsm == ST_ADDR_ACK) || (q.fsm == ST_RX_ACK) || (q.fsm == ST_TX_ACK) ||
                     (q.cnt > 4'h1);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic raise;
    logic [7:0] rx_byte;
    raise = 1'b0;
    rx_byte = 8'h00;
    d = q;

    // two flip-flops per pin before any logic looks at it
    d.pins.scl_meta = scl_in;
    d.pins.scl_sync = q.pins.scl_meta;
    d.pins.scl_prev = q.pins.scl_sync;
    d.pins.sda_meta = sda_in;
    d.pins.sda_sync = q.pins.sda_meta;
    d.pins.sda_prev = q.pins.sda_sync;
    d.si_dly = q.ctrl.si;

    // register writes; writing a one to the flag does nothing
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        ISSS_ADDR_CTRL:
        begin
          d.ctrl.en = reg_wdata_in[ISSS_CTRL_EN_BIT];
          d.ctrl.ie = reg_wdata_in[ISSS_CTRL_IE_BIT];
          d.ctrl.start_request_bit = reg_wdata_in[ISSS_CTRL_START_BIT];
          d.ctrl.stop_request_bit = reg_wdata_in[ISSS_CTRL_STOP_BIT];
          d.ctrl.ack_enable_bit = reg_wdata_in[ISSS_CTRL_ACK_BIT];
          d.ctrl.si = q.ctrl.si & reg_wdata_in[ISSS_CTRL_SI_BIT];
        end
        ISSS_ADDR_DATA: d.serial_data_reg = reg_wdata_in;
        ISSS_ADDR_OWN: d.own_slave_addr_reg = reg_wdata_in;
        // the status byte is read-only, so its writes land here
        default: d.code = q.code;
      endcase
    end

    // read data registered, zero on other cycles
    d.rdata = 8'h00;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        ISSS_ADDR_CTRL: d.rdata = {1'b0, q.ctrl.ie, q.ctrl.start_request_bit, q.ctrl.stop_request_bit,
                                   q.ctrl.si, q.ctrl.ack_enable_bit, 1'b0, q.ctrl.en};
        ISSS_ADDR_STATUS: d.rdata = status_view(q);
        ISSS_ADDR_DATA: d.rdata = q.serial_data_reg;
        default: d.rdata = q.own_slave_addr_reg;
      endcase
    end

    // the stop request drops on a stop on the wire or with the engine off
    if (stop_det || !q.ctrl.en)
      d.ctrl.stop_request_bit = 1'b0;
    rx_byte = {q.shift[6:0], q.pins.sda_sync};

    // ****************************************************************
    // bus sequencer
    // ****************************************************************
    if (!q.ctrl.en)
    begin
      d.fsm = ST_IDLE;
      d.role = ROLE_NONE;
      d.sda_low = 1'b0;
      d.cnt = 4'h0;
    end
    else if ((start_det || stop_det) && (q.fsm != ST_HOLD) && (q.fsm != ST_IDLE) &&
             (addressed || (q.fsm == ST_ADDR)) && mid_frame)
    begin
      d.pcode = ISSS_CODE_BUS_ERR[7:3];
      d.resume = ST_IDLE;
      d.sda_low = 1'b0;
      raise = 1'b1;
    end
    else if ((start_det || stop_det) && addressed && (q.fsm != ST_HOLD))
    begin
      d.pcode = ISSS_CODE_STOP[7:3];
      d.resume = start_det ? ST_ADDR : ST_IDLE;
      d.sda_low = 1'b0;
      raise = 1'b1;
    end
    else if (start_det && (q.fsm != ST_HOLD))
    begin
      d.fsm = ST_ADDR;
      d.cnt = 4'h0;
    end
    else if (stop_det && (q.fsm == ST_ADDR))
      d.fsm = ST_IDLE;
    else
    begin
      case (q.fsm)
        ST_ADDR:
        begin
          if (scl_rise)
          begin
            d.shift = rx_byte;
            d.cnt = 4'(q.cnt + 4'h1);
          end
          else if (scl_fall && (q.cnt == ISSS_BYTE_BITS))
          begin
            d.cnt = 4'h0;
            d.fsm = ST_IDLE;
            // an address is only taken with acknowledge enabled
            if (q.ctrl.ack_enable_bit)
            begin
              if ((q.shift == 8'h00) && q.own_slave_addr_reg[ISSS_OWN_GC_BIT])
              begin
                d.pcode = arb_lost_in ? ISSS_CODE_ARB_GC[7:3] : ISSS_CODE_GC[7:3];
                d.role = ROLE_GC;
                d.resume = ST_RX;
                d.sda_low = 1'b1;
                d.fsm = ST_ADDR_ACK;
              end
              else if (own_match(q.shift, q.own_slave_addr_reg) && !q.shift[0])
              begin
                d.pcode = arb_lost_in ? ISSS_CODE_ARB_SLA_W[7:3] : ISSS_CODE_SLA_W[7:3];
                d.role = ROLE_SR;
                d.resume = ST_RX;
                d.sda_low = 1'b1;
                d.fsm = ST_ADDR_ACK;
              end
              else if (own_match(q.shift, q.own_slave_addr_reg))
              begin
                d.pcode = arb_lost_in ? ISSS_CODE_ARB_SLA_R[7:3] : ISSS_CODE_SLA_R[7:3];
                d.role = ROLE_ST;
                d.resume = ST_TX;
                d.sda_low = 1'b1;
                d.fsm = ST_ADDR_ACK;
              end
            end
          end
        end
        ST_ADDR_ACK, ST_RX_ACK:
        begin
          // end of the ninth clock releases data and reports
          if (scl_fall)
          begin
            d.sda_low = 1'b0;
            raise = 1'b1;
          end
        end
        ST_RX:
        begin
          if (scl_rise)
          begin
            d.shift = rx_byte;
            d.cnt = 4'(q.cnt + 4'h1);
          end
          else if (scl_fall && (q.cnt == ISSS_BYTE_BITS))
          begin
            d.cnt = 4'h0;
            d.serial_data_reg = q.shift;
            d.fsm = ST_RX_ACK;
            d.sda_low = q.ctrl.ack_enable_bit;
            d.resume = q.ctrl.ack_enable_bit ? ST_RX : ST_IDLE;
            if (q.role == ROLE_GC)
            begin
              d.pcode = q.ctrl.ack_enable_bit ? ISSS_CODE_GC_ACK[7:3] : ISSS_CODE_GC_NACK[7:3];
            end
            else
            begin
              d.pcode = q.ctrl.ack_enable_bit ? ISSS_CODE_RX_ACK[7:3] : ISSS_CODE_RX_NACK[7:3];
            end
          end
        end
        ST_TX:
        begin
          if (scl_rise)
            d.cnt = 4'(q.cnt + 4'h1);
          else if (scl_fall && (q.cnt == ISSS_BYTE_BITS))
          begin
            d.sda_low = 1'b0;
            d.fsm = ST_TX_ACK;
          end
          else if (scl_fall)
          begin
            d.sda_low = ~q.shift[7];
            d.shift = {q.shift[6:0], 1'b0};
          end
        end
        ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            d.mack = ~q.pins.sda_sync;
            d.cnt = 4'(q.cnt + 4'h1);
          end
          else if (scl_fall && (q.cnt == ISSS_ACK_BITS))
          begin
            d.cnt = 4'h0;
            raise = 1'b1;
            if (!q.mack)
            begin
              d.pcode = ISSS_CODE_TX_NACK[7:3];
              d.resume = ST_IDLE;
            end
            else if (q.last)
            begin
              d.pcode = ISSS_CODE_TX_LAST[7:3];
              d.resume = ST_IDLE;
            end
            else
            begin
              d.pcode = ISSS_CODE_TX_ACK[7:3];
              d.resume = ST_TX;
            end
          end
        end
        ST_HOLD:
        begin
          if (!q.ctrl.si)
          begin
            d.cnt = 4'h0;
            d.fsm = q.resume;
            if (q.ctrl.stop_request_bit || (q.resume == ST_IDLE))
            begin
              // a stop request in slave mode only drops back to idle
              d.ctrl.stop_request_bit = 1'b0;
              d.fsm = ST_IDLE;
              d.role = ROLE_NONE;
            end
            else if (q.resume == ST_ADDR)
              d.role = ROLE_NONE;
            else if (q.resume == ST_TX)
            begin
              // first bit goes out while the clock is still held low
              d.sda_low = ~q.serial_data_reg[7];
              d.shift = {q.serial_data_reg[6:0], 1'b0};
              d.last = ~q.ctrl.ack_enable_bit;
            end
          end
        end
        default: d.fsm = ST_IDLE;
      endcase
    end

    if (raise)
    begin
      d.code = d.pcode;
      d.ctrl.si = 1'b1;
      d.fsm = ST_HOLD;
      d.cnt = 4'h0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      q <= ISSS_RESET;
    end
    else
      q <= d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // interrupt request gating
  assign irq_out = q.ctrl.si & q.ctrl.ie;
  assign scl_oe_out = (q.fsm == ST_HOLD);
  assign scl_out = 1'b0;
  assign sda_oe_out = q.sda_low;
  assign sda_out = 1'b0;
  assign reg_rdata_out = q.rdata;
  assign role_out = q.role;
endmodule : isss_top

// *** verification/isss_monitor.sv ***
// port checker for the two-wire slave status sequencer
`timescale 1ns/1ns
module isss_monitor
  import isss_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic reset_in, // reset
  input wire logic [1:0] reg_addr_in, // index
  input wire logic [7:0] reg_wdata_in, // write data
  input wire logic reg_wr_in, // write strobe
  input wire logic reg_rd_in, // read strobe
  input wire logic [7:0] reg_rdata_out, // read data
  input wire logic arb_lost_in, // arbitration lost
  input wire logic scl_in, // clock line
  input wire logic scl_out, // clock drive value
  input wire logic scl_oe_out, // clock pulled low
  input wire logic sda_in, // data line
  input wire logic sda_out, // data drive value
  input wire logic sda_oe_out, // data pulled low
  input wire logic irq_out, // interrupt request
  input wire isss_role_t role_out // role
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // ********
  // status reads and flag release steps
  // ********
  sequence s_status_rd;
    reg_rd_in && reg_addr_in == ISSS_ADDR_STATUS;
  endsequence
  sequence s_flag_drop;
    irq_out ##1 !irq_out;
  endsequence

  // the stretch on scl marks a pending flag, so it qualifies the status reads
  a_status_low_zero: assert property (s_status_rd |=> reg_rdata_out[2:0] == 3'h0)
    else $error("status low bits not zero");
  a_idle_code: assert property ((s_status_rd ##0 !scl_oe_out ##1 !scl_oe_out) |-> reg_rdata_out == ISSS_CODE_IDLE)
    else $error("idle status not f8");
  a_code_valid: assert property ((s_status_rd ##0 scl_oe_out) |=> reg_rdata_out != ISSS_CODE_IDLE)
    else $error("status idle while flag pending");
  a_hold_while_flag: assert property (irq_out ##1 irq_out |-> scl_oe_out)
    else $error("clock not held with flag set");
  a_release_after_clear: assert property (s_flag_drop |-> scl_oe_out ##1 !scl_oe_out)
    else $error("clock not released after clear");
  a_flag_sda_free: assert property ($rose(irq_out) |-> !sda_oe_out)
    else $error("data line still driven at flag");
  a_sda_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data drive changed with clock high");
  a_role_slave_only: assert property (role_out != ROLE_MT && role_out != ROLE_MR)
    else $error("master role entered");
  a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
endmodule : isss_monitor

bind isss_top isss_monitor i_isss_monitor (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .arb_lost_in(arb_lost_in), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_out(sda_oe_out), .irq_out(irq_out), .role_out(role_out));

// *** verification/isss_bus_master.sv ***
// behavioural two-wire bus master on the far side of the slave
`timescale 1ns/1ns
module isss_bus_master
(
  input wire logic scl_line_in, // clock line level
  input wire logic sda_line_in, // data line level
  output logic scl_low_out = 1'b0, // pulls clock low
  output logic sda_low_out = 1'b0 // pulls data low
);
  // ********
  // bus phases, 400 ns bit time, free of the system clock phase
  // ********
  // the slave may stretch, so wait for the line itself, not the release
  task automatic scl_high();
    int k = 0;
    scl_low_out = 1'b0;
    while (scl_line_in !== 1'b1 && k < 20000)
    begin
      #10;
      k++;
    end
    #150;
  endtask : scl_high
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    #125;
    sda_low_out = ~b;
    #125;
    scl_high();
    s = sda_line_in;
    scl_low_out = 1'b1;
  endtask : bit_io
  task automatic start();
    #125;
    sda_low_out = 1'b0;
    #125;
    scl_high();
    sda_low_out = 1'b1;
    #200;
    scl_low_out = 1'b1;
  endtask : start
  task automatic stop();
    #125;
    sda_low_out = 1'b1;
    #125;
    scl_high();
    sda_low_out = 1'b0;
    #200;
  endtask : stop
  // most significant bit first; ninth bit 0 drives an acknowledge
  task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(nine, s);
    ack = ~s;
  endtask : xfer
endmodule : isss_bus_master

// *** verification/isss_bench.sv ***
// self-checking bench for the two-wire slave status sequencer
`timescale 1ns/1ns
module isss_bench
  import isss_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] reg_addr_in = 2'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic arb_lost_in = 1'b0;
  logic [7:0] reg_rdata_out, rx, d;
  logic scl_out, scl_oe_out, sda_out, sda_oe_out, irq_out, m_scl_low, m_sda_low, ack;
  isss_role_t role_out;
  int error_cnt = 0;
  int tests_run = 0;
  logic [7:0] t_addr [3] = '{8'h54, 8'h00, 8'h55};
  isss_role_t t_role [3] = '{ROLE_SR, ROLE_GC, ROLE_ST};
  logic [7:0] t_code [6] = '{ISSS_CODE_SLA_W, ISSS_CODE_ARB_SLA_W, ISSS_CODE_GC, ISSS_CODE_ARB_GC, ISSS_CODE_SLA_R,
    ISSS_CODE_ARB_SLA_R};
  // wired-and lines with pull-ups
  wire scl_w = ~(m_scl_low | scl_oe_out);
  wire sda_w = ~(m_sda_low | sda_oe_out);

  always #25 clk_in = ~clk_in;

  isss_top i_isss_top (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .arb_lost_in(arb_lost_in),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_out(scl_oe_out), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .irq_out(irq_out), .role_out(role_out));
  isss_bus_master i_isss_bus_master (.scl_line_in(scl_w), .sda_line_in(sda_w), .scl_low_out(m_scl_low),
    .sda_low_out(m_sda_low));

  // ********
  // register port and checking tasks
  // ********
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask : rd
  // bounded wait for the flag, then code and flag bit
  task automatic svc(input logic [7:0] code);
    int k = 0;
    while (irq_out !== 1'b1 && k < 100)
    begin
      @(posedge clk_in);
      k++;
    end
    chk("irq", 8'h01, {7'h0, irq_out});
    rd(ISSS_ADDR_STATUS, d);
    chk("status", code, d);
    rd(ISSS_ADDR_CTRL, d);
    chk("flag bit", 8'h08, d & 8'h08);
  endtask : svc
  task automatic adr(input logic [7:0] v, input logic [7:0] code);
    i_isss_bus_master.start();
    i_isss_bus_master.xfer(v, 1'b1, rx, ack);
    svc(code);
  endtask : adr
  task automatic wbyte(input logic [7:0] v, input logic a, input logic [7:0] code, input logic [7:0] ctl);
    i_isss_bus_master.xfer(v, 1'b1, rx, ack);
    chk("slave ack", {7'h0, a}, {7'h0, ack});
    svc(code);
    rd(ISSS_ADDR_DATA, d);
    chk("rx data", v, d);
    wr(ISSS_ADDR_CTRL, ctl);
  endtask : wbyte
  task automatic rbyte(input logic [7:0] v, input logic [7:0] ctl, input logic nine, input logic [7:0] code);
    wr(ISSS_ADDR_DATA, v);
    wr(ISSS_ADDR_CTRL, ctl);
    i_isss_bus_master.xfer(8'hff, nine, rx, ack);
    chk("tx data", v, rx);
    svc(code);
  endtask : rbyte
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // watchdog, well beyond the few thousand cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clk_in);
    error_cnt++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(ISSS_ADDR_STATUS, d);
    chk("idle status", ISSS_CODE_IDLE, d);
    wr(ISSS_ADDR_STATUS, 8'h00);
    rd(ISSS_ADDR_STATUS, d);
    chk("status written", ISSS_CODE_IDLE, d);
    wr(ISSS_ADDR_OWN, 8'h55);
    wr(ISSS_ADDR_CTRL, 8'h45);
    // every address kind, plain and after lost arbitration; stop request recovers
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_in);
      arb_lost_in <= (i % 2) == 1;
      adr(t_addr[i / 2], t_code[i]);
      chk("role", {5'h0, t_role[i / 2]}, {5'h0, role_out});
      arb_lost_in <= 1'b0;
      wr(ISSS_ADDR_CTRL, 8'h55);
      i_isss_bus_master.stop();
    end
    // foreign address is left unanswered
    i_isss_bus_master.start();
    i_isss_bus_master.xfer(8'h20, 1'b1, rx, ack);
    chk("foreign ack", 8'h00, {7'h0, ack});
    i_isss_bus_master.stop();
    adr(8'h54, ISSS_CODE_SLA_W);
    wr(ISSS_ADDR_CTRL, 8'h45);
    wbyte(8'ha5, 1'b1, ISSS_CODE_RX_ACK, 8'h41);
    wbyte(8'h3c, 1'b0, ISSS_CODE_RX_NACK, 8'h45);
    i_isss_bus_master.stop();
    adr(8'h00, ISSS_CODE_GC);
    wr(ISSS_ADDR_CTRL, 8'h45);
    wbyte(8'h11, 1'b1, ISSS_CODE_GC_ACK, 8'h41);
    wbyte(8'h22, 1'b0, ISSS_CODE_GC_NACK, 8'h45);
    i_isss_bus_master.stop();
    // stop while still addressed
    adr(8'h54, ISSS_CODE_SLA_W);
    wr(ISSS_ADDR_CTRL, 8'h45);
    wbyte(8'h77, 1'b1, ISSS_CODE_RX_ACK, 8'h45);
    i_isss_bus_master.stop();
    svc(ISSS_CODE_STOP);
    wr(ISSS_ADDR_CTRL, 8'h45);
    // start three bits into a data byte
    adr(8'h54, ISSS_CODE_SLA_W);
    wr(ISSS_ADDR_CTRL, 8'h45);
    repeat (3) i_isss_bus_master.bit_io(1'b1, ack);
    i_isss_bus_master.start();
    svc(ISSS_CODE_BUS_ERR);
    wr(ISSS_ADDR_CTRL, 8'h45);
    i_isss_bus_master.stop();
    // transmit: acked, last byte still acked, then not acked
    adr(8'h55, ISSS_CODE_SLA_R);
    rbyte(8'h96, 8'h45, 1'b0, ISSS_CODE_TX_ACK);
    rbyte(8'h5a, 8'h41, 1'b0, ISSS_CODE_TX_LAST);
    wr(ISSS_ADDR_CTRL, 8'h45);
    i_isss_bus_master.stop();
    adr(8'h55, ISSS_CODE_SLA_R);
    rbyte(8'hc3, 8'h45, 1'b1, ISSS_CODE_TX_NACK);
    wr(ISSS_ADDR_CTRL, 8'h45);
    i_isss_bus_master.stop();
    tally_and_finish();
  end
endmodule : isss_bench
